// ===== src/acc_calib_crc.sv
// What this block does
// - Offset coefficient is subtracted from each channel's result.
// - Offset coefficient is 24-bit two's complement like the output data.
// - Each channel's result is multiplied by its own gain coefficient.
// - Gain is unsigned 24-bit, 800000h is unity, zero at 000000h.
// - Correction always on; reset offsets zero, gains 800000h.
// - Frame check words are 16 bits and cover every frame bit.
// - Input checking enabled by a mode bit, cleared at reset.
// - On input mismatch only register writes still execute.
// - Any input frame check mismatch sets the check-error flag while input checking is enabled.
// - Frame after a mismatch replies as to the idle command.
// - Check-error flag clears when status is shifted out.
// - Every output frame gets a check word appended.
// - One mode bit selects the polynomial for input and output checks.
// - Polynomials are CCITT 1021h and ANSI 8005h.
// - Every check computation starts from all ones.
// - Map check enable bit makes the map check run continuously.
// - Map check walks 02h MSB through 30h LSB with selected polynomial.
// - One map bit per master clock; result stored and compared.
// - Map-changed flag sets whenever the map check value changes, except on the first pass after reset.
// - Map-changed clears on status read or status sent as idle reply.
// - Phase setting shifts the conversion ready strobe timing.
// - Out-of-range phase settings clip to the nearest limit.

module acc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r < (AW+1)'(D));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module acc_calib_crc (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register access from the frame decoder
  input wire logic reg_wr_en,
  input wire logic [5:0] reg_wr_addr,
  input wire logic [acc_pkg::ACC_RW-1:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [5:0] reg_rd_addr,
  output logic [acc_pkg::ACC_RW-1:0] reg_rd_data,
  output logic reg_rd_valid,
  // Status output in a frame
  input wire logic status_shift_out,
  // Received frame bits and check word
  input wire logic rx_frame_start,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_check_valid,
  input wire logic [acc_pkg::ACC_CW-1:0] rx_check_word,
  input wire logic rx_cmd_is_write,
  output logic cmd_decision,
  output logic cmd_allowed,
  output logic reply_as_idle,
  output logic check_error,
  // Transmitted frame bits and check word
  input wire logic tx_frame_start,
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  output logic [acc_pkg::ACC_CW-1:0] tx_check_word,
  // Map check
  output logic map_changed,
  // Master clock pin
  input wire logic master_clock_input,
  // Conversion samples in
  input wire logic conv_tick,
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [acc_pkg::ACC_CHW-1:0] samp_chan,
  input wire logic [acc_pkg::ACC_DW-1:0] samp_data,
  // Corrected samples out
  output logic res_valid,
  input wire logic res_ready,
  output logic [acc_pkg::ACC_CHW-1:0] res_chan,
  output logic [acc_pkg::ACC_DW-1:0] res_data,
  output logic conversion_ready_strobe
);
  import acc_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // Register map 02h..30h
  logic [ACC_RW-1:0] regs_r [ACC_REG_NUM];
  logic [5:0] wr_idx;
  assign wr_idx = reg_wr_addr - ACC_ADDR_FIRST;

  function automatic logic [15:0] reset_of(input logic [5:0] addr);
    if (addr == ACC_ADDR_CLOCK) begin
      reset_of = ACC_RST_CLOCK;
    end else if (addr >= ACC_CH_BASE &&
        ((addr - ACC_CH_BASE) % ACC_CH_STRIDE) == ACC_CH_GCAL_HI) begin
      reset_of = ACC_RST_GCAL_HI;
    end else begin
      reset_of = ACC_RST_ZERO;
    end
  endfunction

  always_ff @(posedge clk) begin
    for (int i = 0; i < ACC_REG_NUM; i++) begin
      if (srst) begin
        regs_r[i] <= reset_of(6'(i) + ACC_ADDR_FIRST);
      end else if (reg_wr_en && reg_wr_addr >= ACC_ADDR_FIRST &&
                   reg_wr_addr <= ACC_ADDR_LAST && wr_idx == 6'(i)) begin
        regs_r[i] <= reg_wr_data;
      end
    end
  end

  logic poly_ansi;
  logic rx_chk_en;
  logic map_chk_en;
  logic [2:0] osr_sel;
  assign poly_ansi = regs_r[0][ACC_MODE_POLY];
  assign rx_chk_en = regs_r[0][ACC_MODE_RX_CHK];
  assign map_chk_en = regs_r[0][ACC_MODE_MAP_CHK];
  assign osr_sel = regs_r[ACC_ADDR_CLOCK - ACC_ADDR_FIRST][ACC_OSR_LSB +: 3];

  function automatic logic [5:0] ch_idx(input logic [2:0] ch,
                                        input logic [5:0] field);
    ch_idx = ACC_CH_BASE - ACC_ADDR_FIRST + 6'(ch) * ACC_CH_STRIDE + field;
  endfunction

  // ==========================================================
  // Offset and gain correction
  logic adv;
  logic fifo_in_ready;
  logic s1_valid_r;
  logic s2_valid_r;
  logic [2:0] s1_chan_r;
  logic [2:0] s2_chan_r;
  logic signed [ACC_DW:0] s1_diff_r;
  logic [ACC_DW-1:0] s1_gain_r;
  logic [ACC_DW-1:0] s2_data_r;
  logic [ACC_DW-1:0] off_sel;
  logic [ACC_DW-1:0] gain_sel;
  logic signed [2*ACC_DW+1:0] prod;
  logic signed [2*ACC_DW+1:0] scaled;
  logic [ACC_DW-1:0] sat;

  assign adv = !s2_valid_r || fifo_in_ready;
  assign off_sel = {regs_r[ch_idx(samp_chan, ACC_CH_OCAL_HI)],
                    regs_r[ch_idx(samp_chan, ACC_CH_OCAL_LO)][15:8]};
  assign gain_sel = {regs_r[ch_idx(samp_chan, ACC_CH_GCAL_HI)],
                     regs_r[ch_idx(samp_chan, ACC_CH_GCAL_LO)][15:8]};
  assign prod = s1_diff_r * $signed({1'b0, s1_gain_r});
  assign scaled = prod >>> ACC_GAIN_SHIFT;

  always_comb begin
    if (scaled > $signed({{27{1'b0}}, 1'b0, {23{1'b1}}})) begin
      sat = {1'b0, {23{1'b1}}};
    end else if (scaled < -$signed({{27{1'b0}}, 1'b1, {23{1'b0}}})) begin
      sat = {1'b1, {23{1'b0}}};
    end else begin
      sat = scaled[ACC_DW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_valid_r <= 1'b0;
      s2_valid_r <= 1'b0;
    end else if (adv) begin
      s1_valid_r <= samp_valid;
      s2_valid_r <= s1_valid_r;
    end
  end

  always_ff @(posedge clk) begin
    if (adv) begin
      s1_chan_r <= samp_chan;
      s1_diff_r <= $signed({samp_data[ACC_DW-1], samp_data}) -
                   $signed({off_sel[ACC_DW-1], off_sel});
      s1_gain_r <= gain_sel;
      s2_chan_r <= s1_chan_r;
      s2_data_r <= sat;
    end
  end

  logic fifo_out_valid;
  logic fifo_take;
  logic [ACC_CHW+ACC_DW-1:0] fifo_out;
  logic res_valid_r;
  logic [ACC_CHW+ACC_DW-1:0] res_r;

  acc_fifo #(.W(ACC_CHW + ACC_DW), .D(ACC_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(s2_valid_r),
    .in_ready(fifo_in_ready),
    .in_data({s2_chan_r, s2_data_r}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_take),
    .out_data(fifo_out)
  );

  assign fifo_take = !res_valid_r || res_ready;

  always_ff @(posedge clk) begin
    if (srst) begin
      res_valid_r <= 1'b0;
      res_r <= '0;
    end else if (fifo_take) begin
      res_valid_r <= fifo_out_valid;
      if (fifo_out_valid) begin
        res_r <= fifo_out;
      end
    end
  end

  assign samp_ready = adv;
  assign res_valid = res_valid_r;
  assign {res_chan, res_data} = res_r;

  // ==========================================================
  // Frame checks
  logic [ACC_CW-1:0] rx_crc_r;
  logic [ACC_CW-1:0] tx_crc_r;
  logic mismatch;
  logic stat_read;
  logic stat_clear;
  logic cmd_decision_r;
  logic cmd_allowed_r;
  logic reply_idle_r;
  logic check_error_r;
  assign mismatch = rx_check_valid && rx_chk_en &&
                    (rx_check_word != rx_crc_r);
  assign stat_read = reg_rd_en && reg_rd_addr == ACC_ADDR_STATUS;
  assign stat_clear = status_shift_out || stat_read;

  always_ff @(posedge clk) begin
    if (srst || rx_frame_start) begin
      rx_crc_r <= ACC_CRC_SEED;
    end else if (rx_bit_valid) begin
      rx_crc_r <= acc_crc_step(rx_crc_r, rx_bit, poly_ansi);
    end
  end

  always_ff @(posedge clk) begin
    if (srst || tx_frame_start) begin
      tx_crc_r <= ACC_CRC_SEED;
    end else if (tx_bit_valid) begin
      tx_crc_r <= acc_crc_step(tx_crc_r, tx_bit, poly_ansi);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_decision_r <= 1'b0;
      cmd_allowed_r <= 1'b0;
      reply_idle_r <= 1'b0;
    end else begin
      cmd_decision_r <= rx_check_valid;
      if (rx_check_valid) begin
        cmd_allowed_r <= !mismatch || rx_cmd_is_write;
        reply_idle_r <= mismatch;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      check_error_r <= 1'b0;
    end else begin
      check_error_r <= mismatch || (check_error_r && !stat_clear);
    end
  end

  assign cmd_decision = cmd_decision_r;
  assign cmd_allowed = cmd_allowed_r;
  assign reply_as_idle = reply_idle_r;
  assign check_error = check_error_r;
  assign tx_check_word = tx_crc_r;

  // ==========================================================
  // Master clock sampling
  logic [2:0] mck_sync_r;
  logic mck_lvl_r;
  logic mck_edge;
  assign mck_edge = mck_sync_r[1] && mck_sync_r[2] && !mck_lvl_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      mck_sync_r <= '0;
      mck_lvl_r <= 1'b0;
    end else begin
      mck_sync_r <= {mck_sync_r[1:0], master_clock_input};
      if (mck_sync_r[1] == mck_sync_r[2]) begin
        mck_lvl_r <= mck_sync_r[2];
      end
    end
  end

  // ==========================================================
  // Register map check
  logic [ACC_MAP_IW-1:0] map_idx_r;
  logic [ACC_CW-1:0] map_crc_r;
  logic [ACC_CW-1:0] map_result_r;
  logic map_have_r;
  logic map_changed_r;
  logic map_bit;
  logic map_last;
  logic [ACC_CW-1:0] map_crc_nxt;
  logic map_set;
  assign map_bit = regs_r[map_idx_r[9:4]][~map_idx_r[3:0]];
  assign map_last = map_idx_r == ACC_MAP_IW'(ACC_MAP_BITS - 1);
  assign map_crc_nxt = acc_crc_step(map_crc_r, map_bit, poly_ansi);
  assign map_set = mck_edge && map_chk_en && map_last && map_have_r &&
                   map_crc_nxt != map_result_r;

  always_ff @(posedge clk) begin
    if (srst || !map_chk_en) begin
      map_idx_r <= '0;
      map_crc_r <= ACC_CRC_SEED;
    end else if (mck_edge) begin
      map_idx_r <= map_last ? '0 : map_idx_r + 1'b1;
      map_crc_r <= map_last ? ACC_CRC_SEED : map_crc_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      map_result_r <= '0;
      map_have_r <= 1'b0;
    end else if (mck_edge && map_chk_en && map_last) begin
      map_result_r <= map_crc_nxt;
      map_have_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      map_changed_r <= 1'b0;
    end else begin
      map_changed_r <= map_set || (map_changed_r && !stat_clear);
    end
  end

  assign map_changed = map_changed_r;

  // ==========================================================
  // Register read port
  logic [ACC_RW-1:0] rd_data_r;
  logic rd_valid_r;
  logic [5:0] rd_idx;
  assign rd_idx = reg_rd_addr - ACC_ADDR_FIRST;

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        if (stat_read) begin
          rd_data_r <= ACC_RW'({check_error_r, map_changed_r});
        end else if (reg_rd_addr == ACC_ADDR_MAP_CHECK) begin
          rd_data_r <= map_result_r;
        end else if (reg_rd_addr >= ACC_ADDR_FIRST &&
                     reg_rd_addr <= ACC_ADDR_LAST) begin
          rd_data_r <= regs_r[rd_idx];
        end else begin
          rd_data_r <= '0;
        end
      end
    end
  end

  assign reg_rd_data = rd_data_r;
  assign reg_rd_valid = rd_valid_r;

  // ==========================================================
  // Phase-shifted ready strobe
  logic signed [ACC_DLY_W-1:0] half_osr;
  logic signed [ACC_DLY_W-1:0] phase;
  logic signed [ACC_DLY_W-1:0] clipped;
  logic [ACC_DLY_W-1:0] dly_r;
  logic dly_busy_r;
  logic strobe_r;
  assign half_osr = (osr_sel >= ACC_OSR_CAP_SEL) ? ACC_HALF_OSR_MAX :
                    ACC_HALF_OSR_MIN << osr_sel;
  assign phase = ACC_DLY_W'($signed(
                 regs_r[ch_idx(3'h0, ACC_CH_CFG)][ACC_PH_LSB +: ACC_PH_W]));

  always_comb begin
    if (phase < -half_osr) begin
      clipped = -half_osr;
    end else if (phase > half_osr - 11'sh001) begin
      clipped = half_osr - 11'sh001;
    end else begin
      clipped = phase;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dly_r <= '0;
      dly_busy_r <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= 1'b0;
      if (conv_tick) begin
        dly_r <= ACC_DLY_W'(clipped + half_osr);
        dly_busy_r <= 1'b1;
      end else if (dly_busy_r && mck_edge) begin
        if (dly_r == '0) begin
          dly_busy_r <= 1'b0;
          strobe_r <= 1'b1;
        end else begin
          dly_r <= dly_r - 1'b1;
        end
      end
    end
  end

  assign conversion_ready_strobe = strobe_r;

  // ==========================================================
  // Checks
  sequence s_bad_frame;
    rx_check_valid && rx_chk_en && rx_check_word != rx_crc_r;
  endsequence

  chk_unity_reset: assert property ($fell(srst) |->
    regs_r[ch_idx(3'h7, ACC_CH_GCAL_HI)] == 16'h8000 &&
    regs_r[ch_idx(3'h7, ACC_CH_OCAL_HI)] == 16'h0000 && !rx_chk_en)
    else $error("coefficients or mode not at reset values");
  chk_corr_path: assert property ((samp_valid && adv) ##1 adv |=>
    s2_data_r == $past(sat) && s2_chan_r == $past(samp_chan, 2))
    else $error("corrected sample lost its channel");
  chk_rx_gate: assert property (s_bad_frame and !rx_cmd_is_write |=>
    cmd_decision_r && !cmd_allowed_r)
    else $error("command allowed after check mismatch");
  chk_rx_off: assert property (rx_check_valid && !rx_chk_en |=>
    cmd_allowed_r && !reply_idle_r)
    else $error("check applied while disabled");
  chk_err_flag: assert property (s_bad_frame |=>
    check_error_r && reply_idle_r)
    else $error("mismatch did not set error and idle reply");
  chk_err_clear: assert property (status_shift_out && !rx_check_valid |=>
    !check_error_r)
    else $error("error flag survived status output");
  chk_tx_seed: assert property (tx_frame_start |=>
    tx_check_word == 16'hffff)
    else $error("output check not seeded with all ones");
  chk_map_flag: assert property (map_set |=> map_changed_r ##1
    (map_changed_r || $past(stat_clear)))
    else $error("map change not flagged");
  chk_map_clear: assert property (stat_read && !map_set |=>
    !map_changed_r)
    else $error("map flag survived status read");
  chk_phase_clip: assert property (conv_tick |=>
    dly_r <= 11'h3ff && dly_r < 11'(2 * half_osr))
    else $error("phase delay outside clipped range");
endmodule

// ===== shared/acc_pkg.sv
package acc_pkg;
  // ==========================================================
  // Widths and sizes
  localparam int ACC_DW = 24;
  localparam int ACC_CW = 16;
  localparam int ACC_RW = 16;
  localparam int ACC_AW = 6;
  localparam int ACC_NCH = 8;
  localparam int ACC_CHW = 3;
  localparam int ACC_FIFO_DEPTH = 8;
  localparam int ACC_REG_NUM = 47;
  localparam int ACC_MAP_BITS = ACC_REG_NUM * ACC_RW;
  localparam int ACC_MAP_IW = 10;
  localparam int ACC_PH_W = 10;
  localparam int ACC_DLY_W = 11;
  localparam int ACC_GAIN_SHIFT = 23;

  // ==========================================================
  // Register addresses
  localparam logic [5:0] ACC_ADDR_STATUS = 6'h01;
  localparam logic [5:0] ACC_ADDR_MODE = 6'h02;
  localparam logic [5:0] ACC_ADDR_CLOCK = 6'h03;
  localparam logic [5:0] ACC_ADDR_FIRST = 6'h02;
  localparam logic [5:0] ACC_ADDR_LAST = 6'h30;
  localparam logic [5:0] ACC_ADDR_MAP_CHECK = 6'h3e;
  localparam logic [5:0] ACC_CH_BASE = 6'h09;
  localparam logic [5:0] ACC_CH_STRIDE = 6'h05;
  localparam logic [5:0] ACC_CH_CFG = 6'h00;
  localparam logic [5:0] ACC_CH_OCAL_HI = 6'h01;
  localparam logic [5:0] ACC_CH_OCAL_LO = 6'h02;
  localparam logic [5:0] ACC_CH_GCAL_HI = 6'h03;
  localparam logic [5:0] ACC_CH_GCAL_LO = 6'h04;

  // ==========================================================
  // Fields and reset values
  localparam int ACC_MODE_POLY = 0;
  localparam int ACC_MODE_RX_CHK = 1;
  localparam int ACC_MODE_MAP_CHK = 2;
  localparam int ACC_OSR_LSB = 2;
  localparam int ACC_PH_LSB = 6;
  localparam int ACC_STAT_MAP = 0;
  localparam int ACC_STAT_ERR = 1;
  localparam logic [15:0] ACC_RST_ZERO = 16'h0000;
  localparam logic [15:0] ACC_RST_GCAL_HI = 16'h8000;
  localparam logic [15:0] ACC_RST_CLOCK = 16'h000c;
  localparam logic [2:0] ACC_OSR_CAP_SEL = 3'h3;
  localparam logic [10:0] ACC_HALF_OSR_MIN = 11'h040;
  localparam logic [10:0] ACC_HALF_OSR_MAX = 11'h200;

  // ==========================================================
  // Check word polynomials and seed
  localparam logic [15:0] ACC_POLY_CCITT = 16'h1021;
  localparam logic [15:0] ACC_POLY_ANSI = 16'h8005;
  localparam logic [15:0] ACC_CRC_SEED = 16'hffff;

  function automatic logic [15:0] acc_crc_step(input logic [15:0] crc,
                                               input logic din,
                                               input logic ansi);
    logic fb;
    fb = crc[15] ^ din;
    acc_crc_step = {crc[14:0], 1'b0} ^
                   (fb ? (ansi ? ACC_POLY_ANSI : ACC_POLY_CCITT) : 16'h0000);
  endfunction
endpackage

// ===== dv/acc_host_model.sv
module acc_host_model (
  // Clock
  input wire logic clk,
  // Frame to the device
  output logic rx_frame_start,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic rx_check_valid,
  output logic [15:0] rx_check_word,
  output logic rx_cmd_is_write,
  // Master clock pin
  output logic master_clock_input
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Pins at rest
  initial begin
    rx_frame_start = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    rx_check_valid = 1'b0;
    rx_check_word = 16'h0000;
    rx_cmd_is_write = 1'b0;
    master_clock_input = 1'b0;
  end

  // Free running, phase unrelated to clk
  always #32 master_clock_input = ~master_clock_input;

  // ==========================================================
  // Host's own check word over a whole 32-bit word
  function automatic logic [15:0] crc_word(input logic [31:0] w,
                                           input logic ansi);
    logic [15:0] c;
    logic [15:0] p;
    c = 16'hffff;
    p = ansi ? 16'h8005 : 16'h1021;
    for (int i = 31; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? p : 16'h0000);
    end
    return c;
  endfunction

  // Sends one word; bad flips a bit of the check word on purpose
  task automatic send(input logic [31:0] w, input logic ansi,
                      input logic wr, input logic bad);
    @(posedge clk);
    rx_frame_start <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk);
      rx_frame_start <= 1'b0;
      rx_bit_valid <= 1'b1;
      rx_bit <= w[i];
    end
    @(posedge clk);
    rx_bit_valid <= 1'b0;
    rx_bit <= ~w[0];
    rx_check_valid <= 1'b1;
    rx_check_word <= crc_word(w, ansi) ^ {15'h0000, bad};
    rx_cmd_is_write <= wr;
    @(posedge clk);
    rx_check_valid <= 1'b0;
    rx_check_word <= ~rx_check_word;
  endtask
endmodule

// ===== dv/acc_calib_crc_tb_top.sv
module acc_calib_crc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acc_pkg::*;
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", nm, e, g); end end

  // ==========================================================
  // Signals
  logic clk, srst, reg_wr_en, reg_rd_en, reg_rd_valid, status_shift_out;
  logic rx_frame_start, rx_bit_valid, rx_bit, rx_check_valid;
  logic rx_cmd_is_write, cmd_decision, cmd_allowed, reply_as_idle;
  logic check_error, tx_frame_start, tx_bit_valid, tx_bit, map_changed;
  logic master_clock_input, conv_tick, samp_valid, samp_ready, res_valid;
  logic res_ready, conversion_ready_strobe;
  logic [5:0] reg_wr_addr, reg_rd_addr;
  logic [15:0] reg_wr_data, reg_rd_data, rx_check_word, tx_check_word, rv;
  logic [2:0] samp_chan, res_chan;
  logic [23:0] samp_data, res_data;
  int compares, miscompares, n, cnt;
  bit ok;

  acc_calib_crc i_acc_calib_crc (.clk, .srst, .reg_wr_en, .reg_wr_addr,
    .reg_wr_data, .reg_rd_en, .reg_rd_addr, .reg_rd_data, .reg_rd_valid,
    .status_shift_out, .rx_frame_start, .rx_bit_valid, .rx_bit,
    .rx_check_valid, .rx_check_word, .rx_cmd_is_write, .cmd_decision,
    .cmd_allowed, .reply_as_idle, .check_error, .tx_frame_start,
    .tx_bit_valid, .tx_bit, .tx_check_word, .map_changed,
    .master_clock_input, .conv_tick, .samp_valid, .samp_ready, .samp_chan,
    .samp_data, .res_valid, .res_ready, .res_chan, .res_data,
    .conversion_ready_strobe);

  acc_host_model i_acc_host_model (.clk, .rx_frame_start, .rx_bit_valid,
    .rx_bit, .rx_check_valid, .rx_check_word, .rx_cmd_is_write,
    .master_clock_input);

  always #2.5 clk = ~clk;

  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      miscompares++;
      $display("Error wait expected %h seen %h", lim, k);
      stop_test();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_wr_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_rd_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, reg_rd_valid)
    rv = reg_rd_data;
  endtask

  task automatic txchk(input logic [31:0] w, input logic ansi);
    @(posedge clk);
    tx_frame_start <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk);
      tx_frame_start <= 1'b0;
      tx_bit_valid <= 1'b1;
      tx_bit <= w[i];
    end
    @(posedge clk);
    tx_bit_valid <= 1'b0;
    #1;
    `CHK("tx_check", i_acc_host_model.crc_word(w, ansi), tx_check_word)
  endtask

  task automatic push(input logic [2:0] c, input logic [23:0] d);
    int k;
    @(posedge clk);
    samp_valid <= 1'b1;
    samp_chan <= c;
    samp_data <= d;
    k = 0;
    @(negedge clk);
    while (samp_ready !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    ok = (k < 20);
    @(posedge clk);
    samp_valid <= 1'b0;
  endtask

  task automatic pull(input logic [23:0] e);
    int k;
    @(posedge clk);
    res_ready <= 1'b1;
    k = 0;
    @(negedge clk);
    while (res_valid !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    tmo(k, 50);
    `CHK("res_data", e, res_data)
    `CHK("res_chan", samp_chan, res_chan)
    @(posedge clk);
    res_ready <= 1'b0;
  endtask

  task automatic tick();
    @(posedge clk);
    conv_tick <= 1'b1;
    @(posedge clk);
    conv_tick <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (conversion_ready_strobe !== 1'b1 && n < 9000);
    tmo(n, 9000);
  endtask

  // Offset first, then gain, clamped to the 24-bit range
  function automatic logic [23:0] cal(input logic [23:0] d,
                                      input logic [23:0] o,
                                      input logic [23:0] g);
    longint v;
    v = (longint'(signed'(d)) - longint'(signed'(o))) * longint'(g);
    v = v >>> 23;
    if (v > 64'sh7fffff) v = 64'sh7fffff;
    if (v < -64'sh800000) v = -64'sh800000;
    return v[23:0];
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    {clk, reg_wr_en, reg_rd_en, status_shift_out, tx_frame_start} = '0;
    {tx_bit_valid, tx_bit, conv_tick, samp_valid, res_ready} = '0;
    {reg_wr_addr, reg_rd_addr, reg_wr_data, samp_chan, samp_data} = '0;
    {compares, miscompares} = '0;
    srst = 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(6'h0c); `CHK("gain_rst", 16'h8000, rv)
    rd(6'h0a); `CHK("offs_rst", 16'h0000, rv)
    rd(6'h3f); `CHK("unmapped", 16'h0000, rv)
    txchk(32'h0123_4567, 1'b0);
    wr(ACC_ADDR_MODE, 16'h0001);
    txchk(32'hfedc_ba98, 1'b1);
    i_acc_host_model.send(32'h0000_1111, 1'b1, 1'b0, 1'b1);
    #1; `CHK("allow_off", 1'b1, cmd_allowed)
    `CHK("err_off", 1'b0, check_error)
    wr(ACC_ADDR_MODE, 16'h0003);
    i_acc_host_model.send(32'h0000_2222, 1'b1, 1'b0, 1'b0);
    #1; `CHK("allow_ok", 1'b1, cmd_allowed)
    `CHK("idle_ok", 1'b0, reply_as_idle)
    i_acc_host_model.send(32'h0000_3333, 1'b1, 1'b0, 1'b1);
    #1; `CHK("decision", 1'b1, cmd_decision)
    `CHK("allow_bad", 1'b0, cmd_allowed)
    `CHK("idle_bad", 1'b1, reply_as_idle)
    `CHK("err_set", 1'b1, check_error)
    i_acc_host_model.send(32'h0000_4444, 1'b1, 1'b1, 1'b1);
    #1; `CHK("allow_wr", 1'b1, cmd_allowed)
    rd(ACC_ADDR_STATUS); `CHK("stat_err", 1'b1, rv[1])
    i_acc_host_model.send(32'h0000_5555, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    status_shift_out <= 1'b1;
    @(posedge clk);
    status_shift_out <= 1'b0;
    #1; `CHK("err_clr", 1'b0, check_error)
    cnt = 0;
    ok = 1'b1;
    while (ok && cnt < 20) begin
      push(3'h0, 24'(cnt * 3 + 1));
      if (ok) cnt++;
    end
    `CHK("refused", 1'b1, cnt >= 8 && cnt < 20)
    for (int i = 0; i < cnt; i++) pull(24'(i * 3 + 1));
    wr(6'h10, 16'h1000);
    wr(6'h11, 16'h4000);
    wr(6'h16, 16'hffff);
    wr(6'h17, 16'hff00);
    wr(6'h19, 16'hffff);
    wr(6'h1a, 16'hff00);
    wr(6'h20, 16'h0000);
    push(3'h1, 24'h000110); pull(cal(24'h110, 24'h10, 24'h400000));
    push(3'h2, 24'h700000); pull(cal(24'h700000, 0, 24'hffffff));
    push(3'h2, 24'h900000); pull(cal(24'h900000, 0, 24'hffffff));
    push(3'h3, 24'h000005); pull(24'h000006);
    push(3'h4, 24'h123456); pull(24'h000000);
    push(3'h0, 24'h000110); pull(24'h000110);
    tick(); `CHK("strobe_dly", 1'b1, n > 6530 && n < 6590)
    wr(6'h03, 16'h0000);
    wr(6'h09, 16'h0800);
    tick(); `CHK("strobe_frac", 1'b1, n > 1215 && n < 1270)
    wr(6'h09, 16'h1900);
    tick(); `CHK("strobe_clip", 1'b1, n > 1600 && n < 1660)
    wr(ACC_ADDR_MODE, 16'h0004);
    repeat (25000) @(posedge clk);
    #1; `CHK("map_steady", 1'b0, map_changed)
    rd(ACC_ADDR_MAP_CHECK);
    cnt = rv;
    wr(6'h13, 16'h0040);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (map_changed !== 1'b1 && n < 25000);
    tmo(n, 25000);
    rd(ACC_ADDR_MAP_CHECK); `CHK("map_new", 1'b1, rv != cnt[15:0])
    rd(ACC_ADDR_STATUS); `CHK("stat_map", 1'b1, rv[0])
    #1; `CHK("map_clr", 1'b0, map_changed)
    stop_test();
  end
endmodule
